/* File: logic/ffsfo_top.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module ffsfo_top
  import ffsfo_pkg::*;
#(
  parameter int FW = FIFO_WIDTH,
  parameter int FD = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Pause enable from the flow-control register of the MAC
  input wire logic tx_pause_enable,
  // Receive frame FIFO accounting, one pulse per stored or drained frame
  input wire logic rx_frame_stored,
  input wire logic [15:0] rx_frame_len,
  input wire logic [15:0] rx_frame_extra,
  input wire logic rx_frame_drained,
  input wire logic [15:0] rx_drain_bytes,
  input wire logic rx_fifo_flush,
  // Occupancy of the other buffers
  input wire logic [15:0] usb_egress_used,
  input wire logic [15:0] usb_ingress_used,
  input wire logic [15:0] tx_fifo_used_bytes,
  // Frame words through the staging FIFO
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [FW-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [FW-1:0] out_data,
  // Results
  output logic [15:0] tx_fifo_end_addr,
  output logic pause_request,
  output logic [15:0] rx_fifo_used_bytes
);
  // ****************************************
  // Helpers
  // ****************************************
  // Frame length rounded up to a whole DWORD; lengths within three of the top
  // wrap, which no real frame reaches
  function automatic logic [15:0] ffsfo_dw_round(input logic [15:0] len);
    ffsfo_dw_round = (len + 16'h0003) & 16'hFFFC;
  endfunction : ffsfo_dw_round

  // Saturating 16-bit sum so the total field never wraps
  function automatic logic [15:0] ffsfo_sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    ffsfo_sat_add = s[16] ? 16'hFFFF : s[15:0];
  endfunction : ffsfo_sat_add

  // ****************************************
  // Address decode
  // ****************************************
  // One code per register; the write and read paths share this decode
  typedef enum logic [2:0] {
    sel_none = 3'h0,
    sel_end = 3'h1,
    sel_flow = 3'h2,
    sel_rx_occ = 3'h3,
    sel_tx_occ = 3'h4,
    sel_status = 3'h5
  } ffsfo_sel_t;

  // Full 8-bit compare, so aliases of a register never respond
  function automatic ffsfo_sel_t ffsfo_decode(input logic [7:0] addr);
    unique case (addr)
      TX_FIFO_END_OFS: ffsfo_decode = sel_end;
      FLOW_WM_OFS: ffsfo_decode = sel_flow;
      RX_PATH_OCC_OFS: ffsfo_decode = sel_rx_occ;
      TX_PATH_OCC_OFS: ffsfo_decode = sel_tx_occ;
      FLOW_STATUS_OFS: ffsfo_decode = sel_status;
      default: ffsfo_decode = sel_none;
    endcase
  endfunction : ffsfo_decode

  ffsfo_sel_t reg_sel;

  // Decoded once for both strobes; they never come together
  assign reg_sel = ffsfo_decode(reg_addr);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [5:0] tx_fifo_end_value_q, tx_fifo_end_value_d;
  logic [6:0] wm_on_q, wm_on_d, wm_off_q, wm_off_d;

  // Writes land only on writable fields; other bits are dropped, so a
  // read-modify-write of a full word can never set a reserved bit
  always_comb begin
    tx_fifo_end_value_d = tx_fifo_end_value_q;
    wm_on_d = wm_on_q;
    wm_off_d = wm_off_q;
    if (reg_wr) begin
      unique case (reg_sel)
        sel_end: begin
          tx_fifo_end_value_d = reg_wdata[TX_END_W-1:0];
        end
        sel_flow: begin
          wm_on_d = reg_wdata[WM_ON_LSB +: WM_W];
          wm_off_d = reg_wdata[WM_OFF_LSB +: WM_W];
        end
        default: begin
          // Occupancy, status and unmapped writes are dropped
        end
      endcase
    end
  end

  // Configuration state; the end value resets to 17h, an end address of 0BFFh
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fifo_end_value_q <= TX_END_RST;
      wm_on_q <= WM_RST;
      wm_off_q <= WM_RST;
    end else begin
      tx_fifo_end_value_q <= tx_fifo_end_value_d;
      wm_on_q <= wm_on_d;
      wm_off_q <= wm_off_d;
    end
  end

  // ****************************************
  // Transmit FIFO end address
  // ****************************************
  // Resizing is not guarded: a change while frames move would corrupt the ring,
  // so software halts the transmit path and flushes it afterwards
  // The low seven bits are always ones: the FIFO ends on a 128-DWORD boundary
  assign tx_fifo_end_addr = {3'h0, tx_fifo_end_value_q, END_ADDR_LOW};

  // ****************************************
  // Receive FIFO used-space counter
  // ****************************************
  logic [15:0] rx_used_q, rx_used_d;
  logic [15:0] add_b, sub_b, rx_sum;

  // Grows per frame by rounded length plus command words and checksums
  always_comb begin
    add_b = rx_frame_stored ? ffsfo_sat_add(ffsfo_dw_round(rx_frame_len), rx_frame_extra)
                            : 16'h0000;
    sub_b = rx_frame_drained ? rx_drain_bytes : 16'h0000;
    // Add first, then subtract, so a store and a drain in one cycle both count
    rx_sum = ffsfo_sat_add(rx_used_q, add_b);
    if (rx_fifo_flush) begin
      rx_used_d = OCC_RST; // Flush wins over a frame in the same cycle
    end else if (rx_sum > sub_b) begin
      rx_used_d = rx_sum - sub_b;
    end else begin
      // A drain larger than the count floors at zero rather than wrapping
      rx_used_d = OCC_RST;
    end
  end

  // Used-space count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rx_used_q <= OCC_RST;
    else rx_used_q <= rx_used_d;
  end

  assign rx_fifo_used_bytes = rx_used_q;

  // ****************************************
  // Pause-frame hysteresis
  // ****************************************
  logic pause_q, pause_d;
  logic [6:0] used_units;

  // Scaling by 512 is a plain shift: a 16-bit count over 512 fits the
  // seven threshold bits exactly, so no saturation stage is needed
  assign used_units = rx_used_q[WM_UNIT_SHIFT +: WM_W];

  logic at_on, at_off;

  // Watermark compares, both inclusive of the threshold itself
  assign at_on = (used_units >= wm_on_q);
  assign at_off = (used_units <= wm_off_q);

  // On wins when both thresholds are met, so a misprogrammed pair still throttles;
  // with reset thresholds of zero an enable turns pause on at once
  always_comb begin
    pause_d = pause_q; // Hold between thresholds
    if (!tx_pause_enable) begin
      pause_d = 1'b0; // Software sets thresholds before this goes high
    end else if (at_on) begin
      pause_d = 1'b1;
    end else if (at_off) begin
      pause_d = 1'b0;
    end
  end

  // Pause state, one cycle behind the count it follows
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) pause_q <= 1'b0;
    else pause_q <= pause_d;
  end

  assign pause_request = pause_q;

  // ****************************************
  // Staging FIFO on the frame word path
  // ****************************************
  logic [$clog2(FD):0] stage_count;

  // Words staged between the frame source and the MAC side. A receive flush
  // also empties it, so no stale word outlives the frame it belonged to;
  // a word pushed in the flush cycle is dropped with the rest
  ffsfo_fifo #(
    .WIDTH(FW),
    .DEPTH(FD)
  ) u_ffsfo_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(rx_fifo_flush),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data),
    .count(stage_count)
  );

  // ****************************************
  // Occupancy sums and read port
  // ****************************************
  logic [15:0] rx_total, tx_total;
  logic [31:0] rdata_d, rdata_q;

  // Totals saturate at the field's top instead of wrapping, so a full path
  // never reads back as nearly empty; the buffers are sampled as they stand
  assign rx_total = ffsfo_sat_add(usb_egress_used, rx_used_q);
  assign tx_total = ffsfo_sat_add(usb_ingress_used, tx_fifo_used_bytes);

  logic [31:0] end_word, flow_word, rx_occ_word, tx_occ_word, status_word;

  // Register images; reserved bits are tied to zero here, not in the mux
  assign end_word = {26'h0, tx_fifo_end_value_q};
  assign flow_word = {17'h0, wm_off_q, 1'b0, wm_on_q};
  assign rx_occ_word = {rx_total, usb_egress_used};
  assign tx_occ_word = {tx_total, usb_ingress_used};
  // Status: pause state at bit 16, staging FIFO fill in the low nibble
  assign status_word = {15'h0, pause_q, 12'h0, 4'(stage_count)};

  // Read mux; unmapped addresses read zero, and so does every idle cycle
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_sel)
        sel_end: begin
          rdata_d = end_word;
        end
        sel_flow: begin
          rdata_d = flow_word;
        end
        sel_rx_occ: begin
          rdata_d = rx_occ_word;
        end
        sel_tx_occ: begin
          rdata_d = tx_occ_word;
        end
        sel_status: begin
          rdata_d = status_word;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 32'h0000_0000;
    else rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;
endmodule : ffsfo_top

/* File: logic/ffsfo_pkg.sv */
package ffsfo_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] TX_FIFO_END_OFS = 8'hCC;
  localparam logic [7:0] FLOW_WM_OFS = 8'hD0;
  localparam logic [7:0] RX_PATH_OCC_OFS = 8'hD4;
  localparam logic [7:0] TX_PATH_OCC_OFS = 8'hD8;
  localparam logic [7:0] FLOW_STATUS_OFS = 8'hDC;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int TX_END_W = 6;
  localparam logic [5:0] TX_END_RST = 6'h17;
  localparam int WM_W = 7;
  localparam int WM_ON_LSB = 0;
  localparam int WM_OFF_LSB = 8;
  localparam logic [6:0] WM_RST = 7'h00;
  localparam int WM_UNIT_SHIFT = 9;
  localparam logic [6:0] END_ADDR_LOW = 7'h7F;
  localparam int OCC_W = 16;
  localparam int TOT_LSB = 16;
  localparam logic [15:0] OCC_RST = 16'h0000;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 32;
endpackage : ffsfo_pkg

/* File: logic/ffsfo_fifo.sv */
`timescale 1ns/1ps
// Small frame-word FIFO with valid/ready on both sides
module ffsfo_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Handshake and pointer next state
  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge ref_clk) begin
    if (push && !flush) mem_q[wr_q] <= in_data;
  end

  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
endmodule : ffsfo_fifo

/* File: dv/ffsfo_sink.sv */
`timescale 1ns/1ps
// ****
// Far-side word consumer; a stall holds ready low
// ****
module ffsfo_sink
  import ffsfo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic out_valid,
  input wire logic [FIFO_WIDTH-1:0] out_data,
  output logic out_ready,
  output logic [FIFO_WIDTH-1:0] last_word,
  output logic [3:0] taken
);
  assign out_ready = !stall;
  // Keep the last word and a count so the bench can see order and loss
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_word <= '0;
      taken <= 4'h0;
    end else if (out_valid && out_ready) begin
      last_word <= out_data;
      taken <= taken + 4'h1;
    end
  end
endmodule : ffsfo_sink

/* File: dv/ffsfo_assertions.sv */
`timescale 1ns/1ps
// ****
// Port checker on the top module's ports
// ****
module ffsfo_chk
  import ffsfo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic tx_pause_enable,
  input wire logic pause_request,
  input wire logic rx_frame_stored,
  input wire logic rx_frame_drained,
  input wire logic rx_fifo_flush,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] rx_frame_len,
  input wire logic [15:0] rx_frame_extra,
  input wire logic [15:0] tx_fifo_end_addr,
  input wire logic [15:0] rx_fifo_used_bytes
);
  logic [6:0] on_q, off_q;
  wire [6:0] lvl = rx_fifo_used_bytes[15:9];
  // Shadow of the thresholds, updated on the same edge as the design
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) {on_q, off_q} <= '0;
    else if (reg_wr && reg_addr == FLOW_WM_OFS) {on_q, off_q} <= {reg_wdata[6:0], reg_wdata[14:8]};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Condition at one edge, pause still enabled at the next
  sequence en2(c);
    c ##1 tx_pause_enable;
  endsequence
  end_low_a: assert property (tx_fifo_end_addr[6:0] == END_ADDR_LOW)
    else $error("end address low bits wrong");
  end_write_a: assert property (reg_wr && reg_addr == TX_FIFO_END_OFS |=>
    tx_fifo_end_addr == {3'h0, $past(reg_wdata[5:0]), END_ADDR_LOW}) else $error("end address");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  flush_clear_a: assert property (rx_fifo_flush |=> rx_fifo_used_bytes == 16'h0)
    else $error("flush did not clear");
  store_add_a: assert property (rx_frame_stored && !rx_frame_drained && !rx_fifo_flush &&
    !rx_fifo_used_bytes[15] && rx_frame_len < 16'h1000 && rx_frame_extra < 16'h1000 |=>
    rx_fifo_used_bytes == $past(rx_fifo_used_bytes) + (($past(rx_frame_len) + 16'h3) &
    16'hFFFC) + $past(rx_frame_extra)) else $error("store count wrong");
  pause_gate_a: assert property (!tx_pause_enable [*2] |-> !pause_request)
    else $error("pause while disabled");
  pause_on_a: assert property (en2(tx_pause_enable && lvl >= on_q) |-> pause_request)
    else $error("pause not on");
  pause_off_a: assert property (en2(tx_pause_enable && lvl <= off_q && lvl < on_q)
    |-> !pause_request) else $error("pause not off");
  pause_hold_a: assert property (en2(tx_pause_enable && $past(tx_pause_enable) &&
    lvl > off_q && lvl < on_q) |-> pause_request == $past(pause_request)) else $error("no hold");
endmodule : ffsfo_chk
bind ffsfo_top ffsfo_chk u_ffsfo_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .tx_pause_enable(tx_pause_enable),
  .pause_request(pause_request),
  .rx_frame_stored(rx_frame_stored),
  .rx_frame_drained(rx_frame_drained),
  .rx_fifo_flush(rx_fifo_flush),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .rx_frame_len(rx_frame_len),
  .rx_frame_extra(rx_frame_extra),
  .tx_fifo_end_addr(tx_fifo_end_addr),
  .rx_fifo_used_bytes(rx_fifo_used_bytes)
);

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import ffsfo_pkg::*;
  logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, tx_pause_enable = 0, stall = 1;
  logic rx_frame_stored = 0, rx_frame_drained = 0, rx_fifo_flush = 0, in_valid = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, in_data = 0, reg_rdata, out_data, last_word;
  logic [15:0] rx_frame_len = 0, rx_frame_extra = 0, rx_drain_bytes = 0, usb_egress_used = 0;
  logic [15:0] usb_ingress_used = 0, tx_fifo_used_bytes = 0, tx_fifo_end_addr, rx_fifo_used_bytes;
  logic in_ready, out_valid, out_ready, pause_request;
  logic [3:0] taken;
  int mismatches = 0, comparisons = 0, cyc = 0;
  ffsfo_top u_ffsfo_top (.*);
  ffsfo_sink u_ffsfo_sink (.*);
  always #50 ref_clk = ~ref_clk;
  // ****
  // Bus cycles, accounting pulses and comparison
  // ****
  task chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there
  task rchk(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk($sformatf("reg_%h", a), e, reg_rdata);
  endtask : rchk
  task pulse(logic s, logic dr, logic fl, logic [15:0] l, logic [15:0] x);
    @(posedge ref_clk);
    {rx_frame_stored, rx_frame_drained, rx_fifo_flush} <= {s, dr, fl};
    {rx_frame_len, rx_frame_extra, rx_drain_bytes} <= {l, x, l};
    @(posedge ref_clk);
    {rx_frame_stored, rx_frame_drained, rx_fifo_flush} <= 3'h0;
  endtask : pulse
  // Pause follows the count one cycle later, hence two negedges
  task step(logic s, logic dr, logic [15:0] eu, logic ep);
    pulse(s, dr, 1'b0, 16'h0200, 16'h0);
    repeat (2) @(negedge ref_clk);
    chk("used", {16'h0, eu}, {16'h0, rx_fifo_used_bytes});
    chk("pause", {31'h0, ep}, {31'h0, pause_request});
  endtask : step
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // ****
  // Scenarios
  // ****
  task t_reset;
    rchk(TX_FIFO_END_OFS, 32'h17);
    chk("end_addr", 32'h0BFF, {16'h0, tx_fifo_end_addr});
    rchk(FLOW_WM_OFS, 32'h0);
    rchk(RX_PATH_OCC_OFS, 32'h0);
    rchk(TX_PATH_OCC_OFS, 32'h0);
    rchk(8'h40, 32'h0);
    $display("test reset done");
  endtask : t_reset
  // Resized only while the transmit path is idle, then the receive FIFO is flushed
  task t_end;
    wr(TX_FIFO_END_OFS, 32'hFFFF_FFC5);
    rchk(TX_FIFO_END_OFS, 32'h5);
    chk("end_addr", 32'h02FF, {16'h0, tx_fifo_end_addr});
    wr(TX_FIFO_END_OFS, 32'h3F);
    rchk(TX_FIFO_END_OFS, 32'h3F);
    chk("end_addr", 32'h1FFF, {16'h0, tx_fifo_end_addr});
    pulse(1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    $display("test end value done");
  endtask : t_end
  task t_occ;
    @(posedge ref_clk);
    {usb_egress_used, usb_ingress_used, tx_fifo_used_bytes} <= {16'h0100, 16'h0200, 16'h0030};
    pulse(1'b1, 1'b0, 1'b0, 16'h5, 16'h4);
    rchk(RX_PATH_OCC_OFS, 32'h010C_0100);
    rchk(TX_PATH_OCC_OFS, 32'h0230_0200);
    wr(RX_PATH_OCC_OFS, 32'hFFFF_FFFF);
    wr(TX_PATH_OCC_OFS, 32'hFFFF_FFFF);
    rchk(RX_PATH_OCC_OFS, 32'h010C_0100);
    rchk(TX_PATH_OCC_OFS, 32'h0230_0200);
    wr(FLOW_WM_OFS, 32'hFFFF_FFFF);
    rchk(FLOW_WM_OFS, 32'h0000_7F7F);
    pulse(1'b0, 1'b0, 1'b1, 16'h0, 16'h0);
    rchk(RX_PATH_OCC_OFS, 32'h0100_0100);
    $display("test occupancy done");
  endtask : t_occ
  // Thresholds on 3 and off 1 written before the enable is raised
  task t_flow;
    wr(FLOW_WM_OFS, 32'h0000_0103);
    @(posedge ref_clk);
    tx_pause_enable <= 1'b1;
    step(1'b1, 1'b0, 16'h0200, 1'b0);
    step(1'b1, 1'b0, 16'h0400, 1'b0);
    step(1'b1, 1'b0, 16'h0600, 1'b1);
    step(1'b0, 1'b1, 16'h0400, 1'b1);
    step(1'b0, 1'b1, 16'h0200, 1'b0);
    $display("test flow done");
  endtask : t_flow
  // Fill the staging FIFO against a stalled sink, then drain it
  task t_fifo;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      {in_valid, in_data} <= {1'b1, 32'hA0 + i};
    end
    @(posedge ref_clk);
    in_valid <= 1'b0;
    @(negedge ref_clk);
    chk("in_ready", 32'h0, {31'h0, in_ready});
    rchk(FLOW_STATUS_OFS, 32'h8);
    @(posedge ref_clk);
    stall <= 1'b0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("taken", 32'h8, {28'h0, taken});
    chk("last_word", 32'hA7, last_word);
    chk("out_valid", 32'h0, {31'h0, out_valid});
    $display("test fifo done");
  endtask : t_fifo
  // A hang counts as a mismatch and ends the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_end();
    t_occ();
    t_flow();
    t_fifo();
    stop_test();
  end
endmodule : testbench
